/* tmps_chan_map.sv */
/*
 * Combinational mapping of a transmit channel number onto its enable bit.
 * Assumes configuration is stable for the cycle in which it is sampled.
 */
`timescale 1ns/1ns
`default_nettype none

module tmps_chan_map
    import tmps_pkg::*;
(
    // Configuration in, enable out
    tmps_map_if.map m
);
    logic [2:0] blk;
    logic [1:0] sel_a;
    logic [1:0] sel_b;

    always_comb
    begin
        blk      = tmps_blk(m.channel);
        sel_a    = (m.mode == TMPS_SEL_SYM) ? m.rx_pa : m.pa_blk;   // [RL4] [RL5]
        sel_b    = (m.mode == TMPS_SEL_SYM) ? m.rx_pb : m.pb_blk;   // [RL4] [RL5]
        m.enable = 1'b0;
        if (m.mode == TMPS_SEL_ALL)
        begin
            // Partition mode has no say when selection is off
            m.enable = 1'b1;                                      // [RL2]
        end
        else if (m.pmode)
        begin
            m.enable = m.cer[blk][m.channel[3:0]];                // [RL7] [RL8]
        end
        else if (blk == tmps_part_blk(sel_a, 1'b0))
        begin
            m.enable = m.cer[0][m.channel[3:0]];                  // [RL3] [RL6] [RL10]
        end
        else if (blk == tmps_part_blk(sel_b, 1'b1))
        begin
            m.enable = m.cer[1][m.channel[3:0]];                  // [RL6] [RL9]
        end
    end
endmodule

`default_nettype wire

/* tmps_map_if.sv */
/*
 * Carries partition configuration to the channel mapper and its answer back.
 * Assumes one clock domain; purely a bundle of wires.
 */
`timescale 1ns/1ns
`default_nettype none

interface tmps_map_if;
    import tmps_pkg::*;
    tmps_sel_mode_t                  mode;
    logic                            pmode;
    logic [1:0]                      pa_blk;
    logic [1:0]                      pb_blk;
    logic [1:0]                      rx_pa;
    logic [1:0]                      rx_pb;
    logic [TMPS_NUM_CER-1:0][15:0]   cer;
    logic [6:0]                      channel;
    logic                            enable;

    modport cfg (output mode, pmode, pa_blk, pb_blk, rx_pa, rx_pb, cer, channel,
                 input enable);
    modport map (input mode, pmode, pa_blk, pb_blk, rx_pa, rx_pb, cer, channel,
                 output enable);
endinterface

`default_nettype wire

/* tmps_pkg.sv */
/*
 * Constants and types for the transmit multichannel partition select block.
 * Assumes a 32-bit AHB-Lite register bus and a 128-channel TDM transmit frame.
 */
package tmps_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int TMPS_CHANS     = 128;
    localparam int TMPS_NUM_CER   = 8;
    localparam int TMPS_CER_W     = 16;
    localparam int TMPS_CH_W      = 7;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] TMPS_CTL_OFF   = 8'h00;
    localparam logic [7:0] TMPS_CER_OFF   = 8'h04;
    localparam logic [7:0] TMPS_RXBLK_OFF = 8'h24;

    // ------------------------------------------------------------------
    // Control and receive block register fields
    // ------------------------------------------------------------------
    localparam int TMPS_PM_BIT  = 9;
    localparam int TMPS_PB_LSB  = 7;
    localparam int TMPS_PA_LSB  = 5;
    localparam int TMPS_CB_LSB  = 2;
    localparam int TMPS_MD_LSB  = 0;
    localparam int TMPS_RXA_LSB = 0;
    localparam int TMPS_RXB_LSB = 2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] TMPS_CTL_RST   = 16'h0000;
    localparam logic [15:0] TMPS_CER_RST   = 16'h0000;
    localparam logic [3:0]  TMPS_RXBLK_RST = 4'h0;

    typedef enum logic [1:0] {
        TMPS_SEL_ALL  = 2'b00,
        TMPS_SEL_EN   = 2'b01,
        TMPS_SEL_MASK = 2'b10,
        TMPS_SEL_SYM  = 2'b11
    } tmps_sel_mode_t;

    // Block of 16 channels that a channel number falls in
    function automatic logic [2:0] tmps_blk(input logic [6:0] ch);
        return ch[6:4];
    endfunction

    // Block chosen by a 2-bit partition field: A takes even, B odd blocks
    function automatic logic [2:0] tmps_part_blk(input logic [1:0] fld, input logic odd);
        return {fld, odd};
    endfunction

endpackage

/* tmps_slot_peer.sv */
/*
 * Transmit framer model: walks the TDM slots 0..127 in order and pulses
 * the slot strobe with each channel number.
 * Assumes the bench raises run and slow just after a rising edge.
 */
`timescale 1ns/1ns
`default_nettype none

module tmps_slot_peer
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst,
    // Pacing from the bench
    input  wire logic       run,
    input  wire logic       slow,
    // Slot strobe to the block
    output var  logic       strobe,
    output var  logic [6:0] channel
);
    logic [6:0] cnt_r;

    // Slow pacing leaves a gap after every slot; the channel bus toggles
    // between slots so a stale number is never mistaken for a live one
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            strobe  <= 1'b0;
            channel <= 7'h00;
            cnt_r   <= 7'h00;
        end
        else if (run && !(slow && strobe))
        begin
            strobe  <= 1'b1;
            channel <= cnt_r;
            cnt_r   <= cnt_r + 7'h01;
        end
        else
        begin
            strobe  <= 1'b0;
            channel <= ~channel;
        end
    end
endmodule

`default_nettype wire

/* tmps_top.sv */
/*
 * Transmit multichannel partition select: control register, eight channel
 * enable registers and the per-slot enable decision for the TDM transmitter.
 * Assumes an AHB-Lite master with single word transfers, and a transmit
 * framer that pulses tx_slot_strobe with the channel number of each slot.
 */
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
//
// Notes on behaviour
// RL1: Control bits 15-10 read zero, ignore writes
// RL2: Partition mode ignored when selection mode zero
// RL3: Mode bit clear gives two partitions, 32 channels
// RL4: Modes 01b/10b use transmit A/B block fields
// RL5: Mode 11b uses receive A/B block fields
// RL6: Partition A gated by enable A, B by B
// RL7: Mode bit set gives eight partitions, 128 channels
// RL8: Eight enables cover consecutive 16-channel groups ascending
// RL9: B field 0-3 selects odd blocks 1,3,5,7
// RL10: A field 0-3 selects even blocks 0,2,4,6
// RL11: Current block tracks activity; reassignment allowed live
// RL12: Reset clears all control register fields
//
`timescale 1ns/1ns
`default_nettype none

module tmps_top
    import tmps_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic        hreadyout,
    output var  logic [31:0] hrdata,
    output var  logic        hresp,
    // Transmit slot interface
    input  wire logic        tx_slot_strobe,
    input  wire logic [6:0]  tx_slot_channel,
    output var  logic        tx_slot_enable,
    output var  logic        tx_slot_valid
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    tmps_sel_mode_t                 mode_r, mode_nxt;
    logic                           pmode_r, pmode_nxt;
    logic [1:0]                     pa_r, pa_nxt;
    logic [1:0]                     pb_r, pb_nxt;
    logic [2:0]                     cblk_r, cblk_nxt;
    logic [3:0]                     rxblk_r, rxblk_nxt;
    logic [TMPS_NUM_CER-1:0][15:0]  cer_r, cer_nxt;

    // Bus data phase
    logic                           dph_wr_r, dph_wr_nxt;
    logic [7:0]                     dph_addr_r, dph_addr_nxt;
    logic [31:0]                    hrdata_r, hrdata_nxt;
    logic                           hready_r;
    // OKAY is the only answer; still a flop so every output is registered
    logic                           hresp_r;

    // Slot outputs
    logic                           en_r, en_nxt;
    logic                           vld_r, vld_nxt;

    logic                           addr_ok;
    logic                           map_en;

    tmps_map_if mif ();

    // ------------------------------------------------------------------
    // Channel mapper
    // ------------------------------------------------------------------
    assign mif.mode    = mode_r;
    assign mif.pmode   = pmode_r;
    assign mif.pa_blk  = pa_r;
    assign mif.pb_blk  = pb_r;
    assign mif.rx_pa   = rxblk_r[TMPS_RXA_LSB +: 2];
    assign mif.rx_pb   = rxblk_r[TMPS_RXB_LSB +: 2];
    assign mif.cer     = cer_r;
    assign mif.channel = tx_slot_channel;
    assign map_en      = mif.enable;

    tmps_chan_map u_map (
        .m (mif.map)
    );

    // Read value of one register, taken from next-state values so that a
    // read right behind a write to the same register sees the new data
    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input tmps_sel_mode_t md,
                                            input logic pm,
                                            input logic [1:0] pa,
                                            input logic [1:0] pb,
                                            input logic [2:0] cb,
                                            input logic [3:0] rxb,
                                            input logic [TMPS_NUM_CER-1:0][15:0] ce);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == TMPS_CTL_OFF)
        begin
            // Upper bits stay zero
            w[TMPS_PM_BIT]         = pm;                          // [RL1]
            w[TMPS_PB_LSB +: 2]    = pb;
            w[TMPS_PA_LSB +: 2]    = pa;
            w[TMPS_CB_LSB +: 3]    = cb;
            w[TMPS_MD_LSB +: 2]    = md;
        end
        else if (a == TMPS_RXBLK_OFF)
        begin
            w[3:0] = rxb;
        end
        else if (a >= TMPS_CER_OFF && a < TMPS_RXBLK_OFF && a[1:0] == 2'b00)
        begin
            w[15:0] = ce[3'(8'(a - TMPS_CER_OFF) >> 2)];
        end
        return w;
    endfunction

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        mode_nxt     = mode_r;
        pmode_nxt    = pmode_r;
        pa_nxt       = pa_r;
        pb_nxt       = pb_r;
        rxblk_nxt    = rxblk_r;
        cer_nxt      = cer_r;
        cblk_nxt     = cblk_r;
        en_nxt       = en_r;
        vld_nxt      = 1'b0;
        addr_ok      = hsel && htrans[1] && hready;
        dph_wr_nxt   = addr_ok && hwrite;
        dph_addr_nxt = addr_ok ? haddr : dph_addr_r;

        // Data phase write; the read-only block field and bits 15-10 drop.
        // Block fields may be rewritten at any time, also mid-frame.
        if (dph_wr_r)
        begin
            if (dph_addr_r == TMPS_CTL_OFF)
            begin
                pmode_nxt = hwdata[TMPS_PM_BIT];                  // [RL1] [RL11]
                pb_nxt    = hwdata[TMPS_PB_LSB +: 2];
                pa_nxt    = hwdata[TMPS_PA_LSB +: 2];
                mode_nxt  = tmps_sel_mode_t'(hwdata[TMPS_MD_LSB +: 2]);
            end
            else if (dph_addr_r == TMPS_RXBLK_OFF)
            begin
                rxblk_nxt = hwdata[3:0];
            end
            else if (dph_addr_r >= TMPS_CER_OFF && dph_addr_r < TMPS_RXBLK_OFF
                     && dph_addr_r[1:0] == 2'b00)
            begin
                cer_nxt[3'(8'(dph_addr_r - TMPS_CER_OFF) >> 2)] = hwdata[15:0];
            end
        end

        // Each slot: latch its enable and show its block as current
        if (tx_slot_strobe)
        begin
            en_nxt   = map_en;
            vld_nxt  = 1'b1;
            cblk_nxt = tmps_blk(tx_slot_channel);                 // [RL11]
        end

        hrdata_nxt = (addr_ok && !hwrite)
                   ? rd_word(haddr, mode_nxt, pmode_nxt, pa_nxt, pb_nxt,
                             cblk_nxt, rxblk_nxt, cer_nxt)
                   : 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mode_r     <= tmps_sel_mode_t'(TMPS_CTL_RST[TMPS_MD_LSB +: 2]); // [RL12]
            pmode_r    <= TMPS_CTL_RST[TMPS_PM_BIT];                     // [RL12]
            pa_r       <= TMPS_CTL_RST[TMPS_PA_LSB +: 2];                // [RL12]
            pb_r       <= TMPS_CTL_RST[TMPS_PB_LSB +: 2];                // [RL12]
            cblk_r     <= TMPS_CTL_RST[TMPS_CB_LSB +: 3];                // [RL12]
            rxblk_r    <= TMPS_RXBLK_RST;
            cer_r      <= {TMPS_NUM_CER{TMPS_CER_RST}};
            dph_wr_r   <= 1'b0;
            dph_addr_r <= 8'h00;
            hrdata_r   <= 32'h0000_0000;
            hready_r   <= 1'b1;
            hresp_r    <= 1'b0;
            en_r       <= 1'b0;
            vld_r      <= 1'b0;
        end
        else
        begin
            mode_r     <= mode_nxt;
            pmode_r    <= pmode_nxt;
            pa_r       <= pa_nxt;
            pb_r       <= pb_nxt;
            cblk_r     <= cblk_nxt;
            rxblk_r    <= rxblk_nxt;
            cer_r      <= cer_nxt;
            dph_wr_r   <= dph_wr_nxt;
            dph_addr_r <= dph_addr_nxt;
            hrdata_r   <= hrdata_nxt;
            hready_r   <= 1'b1;
            hresp_r    <= 1'b0;
            en_r       <= en_nxt;
            vld_r      <= vld_nxt;
        end
    end

    assign hreadyout      = hready_r;
    assign hrdata         = hrdata_r;
    assign hresp          = hresp_r;
    assign tx_slot_enable = en_r;
    assign tx_slot_valid  = vld_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    logic ctl_rd;
    assign ctl_rd = addr_ok && !hwrite && haddr == TMPS_CTL_OFF;

    a_reserved_read_zero: assert property (ctl_rd |=> hrdata_r[31:10] == 22'h0) // [RL1]
        else $error("reserved control bits read nonzero");

    // Mapping checks restate the partition rules apart from the mapper
    a_sel_off_all: assert property ( // [RL2]
        tx_slot_strobe && mode_r == TMPS_SEL_ALL |=> tx_slot_enable && tx_slot_valid)
        else $error("slot disabled while selection mode is off");

    a_two_part_a: assert property ( // [RL4] [RL6] [RL10]
        tx_slot_strobe && mode_r != TMPS_SEL_ALL && mode_r != TMPS_SEL_SYM && !pmode_r
        && tx_slot_channel[6:4] == {pa_r, 1'b0}
        |=> tx_slot_enable == $past(cer_r[0][tx_slot_channel[3:0]]))
        else $error("partition A slot not gated by enable A");

    a_two_part_b: assert property ( // [RL6] [RL9]
        tx_slot_strobe && mode_r != TMPS_SEL_ALL && mode_r != TMPS_SEL_SYM && !pmode_r
        && tx_slot_channel[6:4] == {pb_r, 1'b1}
        |=> tx_slot_enable == $past(cer_r[1][tx_slot_channel[3:0]]))
        else $error("partition B slot not gated by enable B");

    a_two_part_out: assert property ( // [RL3]
        tx_slot_strobe && mode_r != TMPS_SEL_ALL && mode_r != TMPS_SEL_SYM && !pmode_r
        && tx_slot_channel[6:4] != {pa_r, 1'b0} && tx_slot_channel[6:4] != {pb_r, 1'b1}
        |=> !tx_slot_enable)
        else $error("slot outside partitions A and B enabled");

    a_sym_rx_blocks: assert property ( // [RL5]
        tx_slot_strobe && mode_r == TMPS_SEL_SYM && !pmode_r
        && tx_slot_channel[6:4] == {rxblk_r[TMPS_RXA_LSB +: 2], 1'b0}
        |=> tx_slot_enable == $past(cer_r[0][tx_slot_channel[3:0]]))
        else $error("symmetric mode not using receive A block");

    a_eight_part: assert property ( // [RL7] [RL8]
        tx_slot_strobe && mode_r != TMPS_SEL_ALL && pmode_r
        |=> tx_slot_enable == $past(cer_r[tx_slot_channel[6:4]][tx_slot_channel[3:0]]))
        else $error("eight-partition enable mismatch");

    a_cur_block: assert property ( // [RL11]
        tx_slot_strobe ##1 !tx_slot_strobe[*2]
        |-> cblk_r == $past(tx_slot_channel[6:4], 2))
        else $error("current block not held from last slot");

    a_ctl_write: assert property ( // [RL11]
        addr_ok && hwrite && haddr == TMPS_CTL_OFF ##1 1'b1
        |=> pmode_r == $past(hwdata[TMPS_PM_BIT]) && pa_r == $past(hwdata[6:5]))
        else $error("control write not stored");

    // Software must never be able to move the current block field
    a_cblk_read_only: assert property ( // [RL11]
        dph_wr_r && dph_addr_r == TMPS_CTL_OFF && !tx_slot_strobe |=> $stable(cblk_r))
        else $error("current block changed by a register write");

    a_valid_pulse: assert property (tx_slot_valid == $past(tx_slot_strobe))
        else $error("slot valid not one cycle behind strobe");

    a_enable_hold: assert property (!tx_slot_strobe |=> $stable(tx_slot_enable))
        else $error("slot enable moved without a strobe");

    a_unmapped_zero: assert property (
        addr_ok && !hwrite && haddr > TMPS_RXBLK_OFF |=> hrdata_r == 32'h0000_0000)
        else $error("unmapped address read nonzero");

    c_eight_part_slot: cover property (tx_slot_strobe && pmode_r && mode_r != TMPS_SEL_ALL);
    c_two_part_slot:   cover property (tx_slot_strobe && !pmode_r && mode_r == TMPS_SEL_EN);
    c_sym_slot:        cover property (tx_slot_strobe && mode_r == TMPS_SEL_SYM && !pmode_r);
    c_wr_then_rd:      cover property (addr_ok && hwrite ##1 addr_ok && !hwrite);

endmodule

`default_nettype wire

/* tx_multichannel_partition_select_test.sv */
/*
 * Self-checking bench: register access over AHB-Lite, random partition
 * setups with live slot traffic, and a reset once the slot traffic has stopped.
 * Assumes tmps_top answers with no wait states, as handed over.
 */
`timescale 1ns/1ns
`default_nettype none

module tx_multichannel_partition_select_test;
    import tmps_pkg::*;

    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    logic        hsel, hwrite, run, slow, strobe;
    logic        pend  = 1'b0;
    logic        exp_q = 1'b0;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, seed, r;
    logic        hreadyout, hresp, tx_slot_enable, tx_slot_valid;
    logic [6:0]  chan;
    logic [6:0]  last_ch = 7'h00;
    logic [15:0] sh_ctl;
    logic [15:0] sh_cer [8];
    logic [3:0]  sh_rx;
    int          errors, checked, it, k;

    always #2 mclk = ~mclk;

    tmps_top uut (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .tx_slot_strobe(strobe), .tx_slot_channel(chan),
        .tx_slot_enable(tx_slot_enable), .tx_slot_valid(tx_slot_valid));

    tmps_slot_peer peer (.mclk(mclk), .rst(rst), .run(run), .slow(slow),
        .strobe(strobe), .channel(chan));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected slot decision from the bench's copy of the registers
    function automatic logic exp_en(input logic [6:0] ch);
        logic [1:0] md, a, b;
        logic [2:0] blk;
        md  = sh_ctl[1:0];
        blk = ch[6:4];
        a   = (md == TMPS_SEL_SYM) ? sh_rx[1:0] : sh_ctl[6:5];
        b   = (md == TMPS_SEL_SYM) ? sh_rx[3:2] : sh_ctl[8:7];
        if (md == TMPS_SEL_ALL) return 1'b1;
        if (sh_ctl[9]) return sh_cer[blk][ch[3:0]];
        if (blk == {a, 1'b0}) return sh_cer[0][ch[3:0]];
        if (blk == {b, 1'b1}) return sh_cer[1][ch[3:0]];
        return 1'b0;
    endfunction

    task automatic finish_test();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e)
        begin
            $display("unexpected %s expected %h seen %h", name, e, s);
            errors++;
        end
    endtask

    task automatic wait_rdy();
        int i;
        for (i = 0; i < 100; i++)
        begin
            @(posedge mclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 100)
        begin
            $display("unexpected hready expected 1 seen stuck");
            errors++;
            finish_test();
        end
    endtask

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge mclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    // Copy lands just after the storing edge, so the slot taken at that
    // edge is still judged with the old setup, as the design sees it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
        #1;
        if (a == TMPS_CTL_OFF) sh_ctl = d[15:0];
        else if (a == TMPS_RXBLK_OFF) sh_rx = d[3:0];
        else if (a >= TMPS_CER_OFF && a <= TMPS_CER_OFF + 8'h1c && a[1:0] == 2'b00)
            sh_cer[(a - TMPS_CER_OFF) >> 2] = d[15:0];
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0000_0000, q);
        chk(name, e, q);
        chk("hresp", 32'h0000_0000, {31'h0, hresp});
    endtask

    // ------------------------------------------------------------------
    // Slot answer monitor
    // ------------------------------------------------------------------
    always @(posedge mclk)
    begin
        if (pend)
            chk("tx_slot_enable", {31'h0, exp_q}, {31'h0, tx_slot_enable});
        if (!rst)
            chk("tx_slot_valid", {31'h0, pend}, {31'h0, tx_slot_valid});
        pend  <= strobe;
        exp_q <= exp_en(chan);
        if (strobe) last_ch <= chan;
    end

    initial
    begin
        repeat (100000) @(posedge mclk);
        $display("unexpected run length expected done seen timeout");
        errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {hsel, hwrite, run, slow} = 4'h0;
        {haddr, htrans, hwdata, sh_ctl, sh_rx} = '0;
        hsize  = 3'h2;
        seed   = 32'h20d1;
        errors = 0;
        checked = 0;
        for (k = 0; k < 8; k++) sh_cer[k] = 16'h0000;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        rd_chk("ctl", TMPS_CTL_OFF, 32'h0);
        for (k = 0; k < 8; k++) rd_chk("cer", TMPS_CER_OFF + 8'(4 * k), 32'h0);
        rd_chk("rxblk", TMPS_RXBLK_OFF, 32'h0);
        rd_chk("unmapped", 8'h28, 32'h0);
        wr(TMPS_CTL_OFF, 32'hffff_ffff);
        rd_chk("ctl", TMPS_CTL_OFF, 32'h0000_03e3);
        // Every mode with both partition settings; writes land mid-frame
        for (it = 0; it < 24; it++)
        begin
            r = xs();
            @(posedge mclk);
            run  <= 1'b1;
            slow <= r[31];
            wr(TMPS_CTL_OFF, {16'h0, r[15:10], it[2], r[8:2], it[1:0]});
            for (k = 0; k < 8; k++) wr(TMPS_CER_OFF + 8'(4 * k), xs());
            wr(TMPS_RXBLK_OFF, xs());
            wr(TMPS_CTL_OFF, {16'h0, sh_ctl ^ 16'h0180});
            repeat (200 + int'(r[23:16])) @(posedge mclk);
            run <= 1'b0;
            repeat (3) @(posedge mclk);
            rd_chk("ctl", TMPS_CTL_OFF, {22'h0, sh_ctl[9:5], last_ch[6:4], sh_ctl[1:0]});
        end
        // Second reset, with slot traffic stopped, clears the setup again
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rd_chk("ctl", TMPS_CTL_OFF, 32'h0);
        rd_chk("cer", TMPS_CER_OFF, 32'h0);
        finish_test();
    end
endmodule

`default_nettype wire
